// [common/pond_pkg.sv]
// Purpose: shared constants for the pattern output next-data block
// Assumes: 16-bit register addresses, 8-bit register data
// Notes: all offsets, reset values and field positions live here
package pond_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_GRP = 4;
	localparam int GRP_W = 4;
	localparam int SEL_W = 2;
	localparam int REG_W = 8;
	localparam int ADDR_W = 16;
	localparam int PIN_W = NUM_GRP * GRP_W;

	typedef logic [ADDR_W-1:0] pond_addr_t;
	typedef logic [REG_W-1:0] pond_byte_t;
	typedef logic [GRP_W-1:0] pond_nib_t;

	// ****************************************
	// register offsets
	// ****************************************
	localparam pond_addr_t ADDR_TRIG_SEL = 16'hFFA1;
	localparam pond_addr_t ADDR_EN_HI = 16'hFFA2;
	localparam pond_addr_t ADDR_EN_LO = 16'hFFA3;
	localparam pond_addr_t ADDR_NDB_UP = 16'hFFA4;
	localparam pond_addr_t ADDR_NDA_UP = 16'hFFA5;
	localparam pond_addr_t ADDR_NDB_LO = 16'hFFA6;
	localparam pond_addr_t ADDR_NDA_LO = 16'hFFA7;
	localparam pond_addr_t ADDR_LATCH_A = 16'hFFD3;
	localparam pond_addr_t ADDR_LATCH_B = 16'hFFD6;

	// ****************************************
	// reset and fixed read values
	// ****************************************
	localparam pond_byte_t RST_NEXT = 8'h00;
	localparam pond_byte_t RST_EN = 8'h00;
	localparam pond_byte_t RST_TRIG_SEL = 8'hFF;
	localparam pond_byte_t RST_LATCH = 8'h00;
	localparam pond_nib_t RSV_NIB = 4'hF;
	localparam pond_byte_t RSV_BYTE = 8'hFF;
	localparam pond_byte_t RD_UNMAPPED = 8'h00;
	localparam pond_byte_t RST_RD_DATA = 8'h00;
	localparam logic RST_SYNC_STBY_N = 1'b1;

	// ****************************************
	// field positions
	// ****************************************
	localparam int SEL_STRIDE = 2;
	localparam int NIB_HI_LSB = 4;
	localparam int NIB_LO_LSB = 0;

endpackage

// [common/pond_grp_if.sv]
// Purpose: carrier between the top and one output group
// Assumes: all signals on ref_clk, combinational across the link
// Notes: one instance per group
interface pond_grp_if;
	import pond_pkg::*;

	logic [SEL_W-1:0] sel;
	logic [NUM_GRP-1:0] cmp;
	pond_nib_t nextData;
	pond_nib_t enable;
	pond_nib_t latch;
	pond_nib_t latchNxt;
	logic fire;

	modport grp (
		input sel,
		input cmp,
		input nextData,
		input enable,
		input latch,
		output fire,
		output latchNxt
	);

	modport top (
		output sel,
		output cmp,
		output nextData,
		output enable,
		output latch,
		input fire,
		input latchNxt
	);

endinterface

// [core/pond_sync.sv]
// Purpose: two-flop synchroniser for a pin level
// Assumes: pin is asynchronous to ref_clk
// Notes: only the second stage is visible outside
module pond_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic pinIn,
	output logic pinOut
);
	logic stage1_r;
	logic stage2_r;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			stage1_r <= RST_VAL;
			stage2_r <= RST_VAL;
		end else if (clkEn) begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
		end
	end

	assign pinOut = stage2_r;
endmodule // pond_sync

// [core/pond_group.sv]
// Purpose: trigger selection and masked transfer for one 4-pin group
// Assumes: compare-match strobes are one-cycle pulses on ref_clk
// Notes: purely combinational, the latch flops sit in the top
module pond_group (
	pond_grp_if.grp grp
);
	import pond_pkg::*;

	logic [GRP_W-1:0] load;

	// pick one of the four compare-match strobes
	assign grp.fire = grp.cmp[grp.sel];

	// only enabled bits take next data, all in the strobe cycle
	assign load = grp.fire ? grp.enable : '0;
	assign grp.latchNxt = (load & grp.nextData) | (~load & grp.latch);
endmodule // pond_group

// [core/pond_top.sv]
// Purpose: next-data transfer logic of a 16-pin timing pattern output unit
// Assumes: timer strobes on ref_clk; standby pin asynchronous
// Notes: non-overlap mode and direction control are not part of this block
//
// The implementer's own choice: strobed register access.
module pond_top (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic hwStandby_n,
	input wire logic [pond_pkg::NUM_GRP-1:0] cmpMatch,
	input wire pond_pkg::pond_addr_t regAddr,
	input wire pond_pkg::pond_byte_t regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output pond_pkg::pond_byte_t regRdData,
	output pond_pkg::pond_byte_t portALatch,
	output pond_pkg::pond_byte_t portBLatch
);
	import pond_pkg::*;

	// ****************************************
	// state
	// ****************************************
	pond_byte_t trigSel_r;
	pond_byte_t enLo_r;
	pond_byte_t enHi_r;
	pond_byte_t ndA_r;
	pond_byte_t ndB_r;
	pond_byte_t latA_r;
	pond_byte_t latB_r;
	pond_byte_t rdData_r;

	pond_byte_t trigSel_nxt;
	pond_byte_t enLo_nxt;
	pond_byte_t enHi_nxt;
	pond_byte_t ndA_nxt;
	pond_byte_t ndB_nxt;
	pond_byte_t latA_nxt;
	pond_byte_t latB_nxt;
	pond_byte_t rdData_nxt;

	// ****************************************
	// hardware standby and clear
	// ****************************************
	logic stbySync_n;
	logic clr;
	logic stbyClr;

	pond_sync #(
		.RST_VAL(RST_SYNC_STBY_N)
	) u_stby (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.clkEn(clkEn),
		.pinIn(hwStandby_n),
		.pinOut(stbySync_n)
	);

	// standby clears only while clocked, reset always acts
	assign stbyClr = clkEn && !stbySync_n;
	assign clr = !reset_n || stbyClr;

	// ****************************************
	// group trigger selects
	// ****************************************
	logic [SEL_W-1:0] grpSel [NUM_GRP];
	logic sameA;
	logic sameB;

	genvar g;
	generate
		for (g = 0; g < NUM_GRP; g++) begin : g_sel
			assign grpSel[g] = trigSel_r[g*SEL_STRIDE +: SEL_W];
		end
	endgenerate

	assign sameA = grpSel[1] == grpSel[0];
	assign sameB = grpSel[3] == grpSel[2];

	// ****************************************
	// address match
	// ****************************************
	logic hitTrigSel;
	logic hitEnHi;
	logic hitEnLo;
	logic hitNdaUp;
	logic hitNdaLo;
	logic hitNdbUp;
	logic hitNdbLo;
	logic hitLatA;
	logic hitLatB;

	assign hitTrigSel = regAddr == ADDR_TRIG_SEL;
	assign hitEnHi = regAddr == ADDR_EN_HI;
	assign hitEnLo = regAddr == ADDR_EN_LO;
	assign hitNdaUp = regAddr == ADDR_NDA_UP;
	assign hitNdaLo = regAddr == ADDR_NDA_LO;
	assign hitNdbUp = regAddr == ADDR_NDB_UP;
	assign hitNdbLo = regAddr == ADDR_NDB_LO;
	assign hitLatA = regAddr == ADDR_LATCH_A;
	assign hitLatB = regAddr == ADDR_LATCH_B;

	// ****************************************
	// write decode
	// ****************************************
	logic wrTrigSel;
	logic wrEnHi;
	logic wrEnLo;
	logic wrNdaUp;
	logic wrNdaLo;
	logic wrNdbUp;
	logic wrNdbLo;
	logic wrLatA;
	logic wrLatB;

	assign wrTrigSel = regWr && hitTrigSel;
	assign wrEnHi = regWr && hitEnHi;
	assign wrEnLo = regWr && hitEnLo;
	assign wrNdaUp = regWr && hitNdaUp;
	// companion address is read-only while the pair shares a trigger
	assign wrNdaLo = regWr && hitNdaLo && !sameA;
	assign wrNdbUp = regWr && hitNdbUp;
	assign wrNdbLo = regWr && hitNdbLo && !sameB;
	assign wrLatA = regWr && hitLatA;
	assign wrLatB = regWr && hitLatB;

	// ****************************************
	// nibble views
	// ****************************************
	pond_nib_t wrNibHi;
	pond_nib_t wrNibLo;
	pond_nib_t ndaHi;
	pond_nib_t ndaLo;
	pond_nib_t ndbHi;
	pond_nib_t ndbLo;

	assign wrNibHi = regWrData[NIB_HI_LSB +: GRP_W];
	assign wrNibLo = regWrData[NIB_LO_LSB +: GRP_W];
	assign ndaHi = ndA_r[NIB_HI_LSB +: GRP_W];
	assign ndaLo = ndA_r[NIB_LO_LSB +: GRP_W];
	assign ndbHi = ndB_r[NIB_HI_LSB +: GRP_W];
	assign ndbLo = ndB_r[NIB_LO_LSB +: GRP_W];

	// ****************************************
	// next-data buffer write paths
	// ****************************************
	pond_byte_t ndaUpVal;
	pond_byte_t ndaLoVal;
	pond_byte_t ndbUpVal;
	pond_byte_t ndbLoVal;

	// shared trigger takes the whole byte, split trigger only the high nibble
	assign ndaUpVal = sameA ? regWrData : {wrNibHi, ndaLo};
	assign ndaLoVal = {ndaHi, wrNibLo};
	assign ndbUpVal = sameB ? regWrData : {wrNibHi, ndbLo};
	assign ndbLoVal = {ndbHi, wrNibLo};

	assign ndA_nxt = wrNdaUp ? ndaUpVal : (wrNdaLo ? ndaLoVal : ndA_r);
	assign ndB_nxt = wrNdbUp ? ndbUpVal : (wrNdbLo ? ndbLoVal : ndB_r);

	// ****************************************
	// control register write paths
	// ****************************************
	assign trigSel_nxt = wrTrigSel ? regWrData : trigSel_r;
	assign enLo_nxt = wrEnLo ? regWrData : enLo_r;
	assign enHi_nxt = wrEnHi ? regWrData : enHi_r;

	// ****************************************
	// output groups
	// ****************************************
	logic [PIN_W-1:0] nextAll;
	logic [PIN_W-1:0] enAll;
	logic [PIN_W-1:0] latchAll;
	logic [PIN_W-1:0] xferAll;

	assign nextAll = {ndB_r, ndA_r};
	assign enAll = {enHi_r, enLo_r};
	assign latchAll = {latB_r, latA_r};

	pond_grp_if gIf [NUM_GRP] ();

	generate
		for (g = 0; g < NUM_GRP; g++) begin : g_grp
			assign gIf[g].sel = grpSel[g];
			assign gIf[g].cmp = cmpMatch;
			assign gIf[g].nextData = nextAll[g*GRP_W +: GRP_W];
			assign gIf[g].enable = enAll[g*GRP_W +: GRP_W];
			assign gIf[g].latch = latchAll[g*GRP_W +: GRP_W];
			assign xferAll[g*GRP_W +: GRP_W] = gIf[g].latchNxt;

			pond_group u_grp (
				.grp(gIf[g])
			);
		end
	endgenerate

	// ****************************************
	// port output latches
	// ****************************************
	pond_byte_t swA;
	pond_byte_t swB;
	pond_byte_t xferA;
	pond_byte_t xferB;
	pond_byte_t lockA;
	pond_byte_t lockB;

	assign swA = wrLatA ? regWrData : latA_r;
	assign swB = wrLatB ? regWrData : latB_r;
	assign xferA = xferAll[0 +: REG_W];
	assign xferB = xferAll[REG_W +: REG_W];

	// enabled bits follow the transfer only, software reaches the rest
	assign lockA = enLo_r;
	assign lockB = enHi_r;
	assign latA_nxt = (lockA & xferA) | (~lockA & swA);
	assign latB_nxt = (lockB & xferB) | (~lockB & swB);

	// ****************************************
	// read path
	// ****************************************
	pond_byte_t rdNdaUp;
	pond_byte_t rdNdaLo;
	pond_byte_t rdNdbUp;
	pond_byte_t rdNdbLo;
	pond_byte_t rdMux;

	assign rdNdaUp = sameA ? ndA_r
		: {ndA_r[NIB_HI_LSB +: GRP_W], RSV_NIB};
	assign rdNdaLo = sameA ? RSV_BYTE
		: {RSV_NIB, ndA_r[NIB_LO_LSB +: GRP_W]};
	assign rdNdbUp = sameB ? ndB_r
		: {ndB_r[NIB_HI_LSB +: GRP_W], RSV_NIB};
	assign rdNdbLo = sameB ? RSV_BYTE
		: {RSV_NIB, ndB_r[NIB_LO_LSB +: GRP_W]};

	assign rdMux = hitTrigSel ? trigSel_r
		: hitEnHi ? enHi_r
		: hitEnLo ? enLo_r
		: hitNdaUp ? rdNdaUp
		: hitNdaLo ? rdNdaLo
		: hitNdbUp ? rdNdbUp
		: hitNdbLo ? rdNdbLo
		: hitLatA ? latA_r
		: hitLatB ? latB_r
		: RD_UNMAPPED;

	// read data stand for the one cycle after the strobe only
	assign rdData_nxt = regRd ? rdMux : RST_RD_DATA;

	// ****************************************
	// registers
	// ****************************************
	// trigger select
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			trigSel_r <= RST_TRIG_SEL;
		end else if (clkEn) begin
			trigSel_r <= trigSel_nxt;
		end
	end

	// low pin enables
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			enLo_r <= RST_EN;
		end else if (clkEn) begin
			enLo_r <= enLo_nxt;
		end
	end

	// high pin enables
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			enHi_r <= RST_EN;
		end else if (clkEn) begin
			enHi_r <= enHi_nxt;
		end
	end

	// next data for port A
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			ndA_r <= RST_NEXT;
		end else if (clkEn) begin
			ndA_r <= ndA_nxt;
		end
	end

	// next data for port B
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			ndB_r <= RST_NEXT;
		end else if (clkEn) begin
			ndB_r <= ndB_nxt;
		end
	end

	// port A latch
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			latA_r <= RST_LATCH;
		end else if (clkEn) begin
			latA_r <= latA_nxt;
		end
	end

	// port B latch
	always_ff @(posedge ref_clk) begin
		if (clr) begin
			latB_r <= RST_LATCH;
		end else if (clkEn) begin
			latB_r <= latB_nxt;
		end
	end

	// read data
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rdData_r <= RST_RD_DATA;
		end else if (clkEn) begin
			rdData_r <= rdData_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign regRdData = rdData_r;
	assign portALatch = latA_r;
	assign portBLatch = latB_r;
endmodule // pond_top

// [dv/pond_pin_load.sv]
// Purpose: external loads on the sixteen pattern pins
// Assumes: pins left as inputs float high on a pull-up
// Notes: pin levels sampled each clock
module pond_pin_load (
	input wire logic ref_clk,
	input wire logic [15:0] portDir,
	input wire logic [15:0] pinDrive,
	output logic [15:0] pinSeen
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge ref_clk) pinSeen <= (pinDrive & portDir) | ~portDir;
endmodule // pond_pin_load

// [dv/pond_top_assertions.sv]
// Purpose: port checks for pond_top
// Assumes: shadows follow register writes
// Notes: checks other than the reserved-nibble reads pause while standby settles
module pond_top_assertions (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic hwStandby_n,
	input wire logic [pond_pkg::NUM_GRP-1:0] cmpMatch,
	input wire pond_pkg::pond_addr_t regAddr,
	input wire pond_pkg::pond_byte_t regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire pond_pkg::pond_byte_t regRdData,
	input wire pond_pkg::pond_byte_t portALatch,
	input wire pond_pkg::pond_byte_t portBLatch
);
	timeunit 1ns;
	timeprecision 1ns;
	import pond_pkg::*;
	logic [3:0] stby_r;
	pond_byte_t trig_r;
	pond_byte_t enLo_r;
	pond_byte_t enHi_r;
	logic [15:0] fire;
	wire quiet = hwStandby_n && (&stby_r);
	wire rdOk = regRd && clkEn;
	wire pond_byte_t keepA = ~(enLo_r | {8{regWr && regAddr == ADDR_LATCH_A}});
	wire pond_byte_t keepB = ~(enHi_r | {8{regWr && regAddr == ADDR_LATCH_B}});
	wire pond_byte_t lockA = enLo_r & ~fire[7:0];
	wire pond_byte_t lockB = enHi_r & ~fire[15:8];
	always_comb
		for (int g = 0; g < NUM_GRP; g++)
			fire[4*g+:4] = {4{cmpMatch[trig_r[2*g+:2]]}};
	always_ff @(posedge ref_clk) begin
		stby_r <= reset_n ? {stby_r[2:0], hwStandby_n} : 4'hF;
		if (!reset_n || !quiet) begin
			trig_r <= RST_TRIG_SEL;
			enLo_r <= RST_EN;
			enHi_r <= RST_EN;
		end else if (regWr && clkEn) begin
			if (regAddr == ADDR_TRIG_SEL) trig_r <= regWrData;
			if (regAddr == ADDR_EN_LO) enLo_r <= regWrData;
			if (regAddr == ADDR_EN_HI) enHi_r <= regWrData;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	property p_ndaRes; rdOk && regAddr == ADDR_NDA_LO |=> regRdData[7:4] == RSV_NIB; endproperty
	a_ndaRes: assert property (p_ndaRes) else $error("reserved nibble");
	property p_ndbRes; rdOk && regAddr == ADDR_NDB_LO |=> regRdData[7:4] == RSV_NIB; endproperty
	a_ndbRes: assert property (p_ndbRes) else $error("reserved nibble");
	property p_trigRd;
		rdOk && quiet && regAddr == ADDR_TRIG_SEL |=> regRdData == $past(trig_r); endproperty
	a_trigRd: assert property (p_trigRd) else $error("trigger select read");
	property p_enRd; rdOk && quiet && regAddr == ADDR_EN_HI |=> regRdData == $past(enHi_r);
	endproperty
	a_enRd: assert property (p_enRd) else $error("enable read");
	property p_disA; quiet |=> ((portALatch ^ $past(portALatch)) & $past(keepA)) == 0; endproperty
	a_disA: assert property (p_disA) else $error("disabled bit moved");
	property p_disB; quiet |=> ((portBLatch ^ $past(portBLatch)) & $past(keepB)) == 0; endproperty
	a_disB: assert property (p_disB) else $error("disabled bit moved");
	property p_roA; quiet |=> ((portALatch ^ $past(portALatch)) & $past(lockA)) == 0; endproperty
	a_roA: assert property (p_roA) else $error("locked bit moved");
	property p_roB; quiet |=> ((portBLatch ^ $past(portBLatch)) & $past(lockB)) == 0; endproperty
	a_roB: assert property (p_roB) else $error("locked bit moved");
	cover property (regWr && regAddr == ADDR_LATCH_A && |enLo_r);
	cover property (|(fire & {enHi_r, enLo_r}));
	cover property (rdOk && regAddr == ADDR_NDB_LO);
endmodule // pond_top_assertions
bind pond_top pond_top_assertions pond_top_assertions_i (.ref_clk, .reset_n, .clkEn,
	.hwStandby_n, .cmpMatch, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .portALatch,
	.portBLatch);

// [dv/pond_top_tb.sv]
// Purpose: self-checking bench for pond_top
// Assumes: clkEn held high except in the freeze test; all pattern pins set as outputs
// Notes: one task per scenario
module pond_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pond_pkg::*;
	logic ref_clk = 1'h0;
	logic reset_n = 1'h0;
	logic clkEn = 1'h1;
	logic hwStandby_n = 1'h1;
	logic regWr = 1'h0;
	logic regRd = 1'h0;
	logic [NUM_GRP-1:0] cmpMatch = '0;
	pond_addr_t regAddr = '0;
	pond_byte_t regWrData = '0;
	pond_byte_t regRdData;
	pond_byte_t portALatch;
	pond_byte_t portBLatch;
	logic [PIN_W-1:0] pinSeen;
	logic [PIN_W-1:0] expPins = '0;
	int failCount = 0;
	int checks = 0;
	int cycles = 0;
	pond_top pond_top_i (.ref_clk, .reset_n, .clkEn, .hwStandby_n, .cmpMatch, .regAddr,
		.regWrData, .regWr, .regRd, .regRdData, .portALatch, .portBLatch);
	pond_pin_load pond_pin_load_i (.ref_clk, .portDir(16'hFFFF),
		.pinDrive({portBLatch, portALatch}), .pinSeen);
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failCount++;
			finishTest();
		end
	end
	task automatic finishTest();
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string name, pond_byte_t exp, pond_byte_t got);
		checks++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(pond_addr_t a, pond_byte_t d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'h1;
		@(posedge ref_clk);
		regWr <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic rd(pond_addr_t a, pond_byte_t exp);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge ref_clk);
		regRd <= 1'h0;
		#1 chk($sformatf("reg %h", a), exp, regRdData);
		@(posedge ref_clk);
	endtask
	task automatic pulse(logic [NUM_GRP-1:0] m);
		cmpMatch <= m;
		@(posedge ref_clk);
		cmpMatch <= '0;
		#1 chk("portALatch", expPins[7:0], portALatch);
		chk("portBLatch", expPins[15:8], portBLatch);
		@(posedge ref_clk);
	endtask
	task automatic chkCleared();
		rd(ADDR_TRIG_SEL, RST_TRIG_SEL);
		rd(ADDR_EN_LO, RST_EN);
		rd(ADDR_EN_HI, RST_EN);
		rd(ADDR_NDA_UP, RST_NEXT);
		rd(ADDR_NDB_UP, RST_NEXT);
		rd(ADDR_NDA_LO, RSV_BYTE);
		rd(ADDR_NDB_LO, RSV_BYTE);
		rd(ADDR_LATCH_A, RST_LATCH);
		rd(ADDR_LATCH_B, RST_LATCH);
	endtask
	task automatic tLayout();
		wr(ADDR_TRIG_SEL, 8'hE4);
		wr(ADDR_NDA_UP, 8'hA5);
		wr(ADDR_NDA_LO, 8'h3C);
		wr(ADDR_NDB_LO, 8'h7E);
		rd(ADDR_NDA_UP, 8'hAF);
		rd(ADDR_NDA_LO, 8'hFC);
		rd(ADDR_NDB_LO, 8'hFE);
		wr(ADDR_NDA_UP, 8'hA6);
		rd(ADDR_NDA_LO, 8'hFC);
		wr(ADDR_TRIG_SEL, 8'h00);
		wr(ADDR_NDA_LO, 8'h12);
		rd(ADDR_NDA_LO, RSV_BYTE);
		rd(ADDR_NDA_UP, 8'hAC);
		rd(ADDR_NDB_UP, 8'h0E);
		$display("test layout done");
	endtask
	task automatic tXfer();
		pond_byte_t sel;
		logic [3:0] nib [NUM_GRP];
		wr(ADDR_EN_LO, 8'hFF);
		wr(ADDR_EN_HI, 8'hFF);
		for (int k = 0; k < NUM_GRP; k++) begin
			for (int g = 0; g < NUM_GRP; g++) begin
				sel[2*g+:2] = 2'(g + k);
				nib[g] = 4'(5 * k + g + 1);
			end
			wr(ADDR_TRIG_SEL, sel);
			wr(ADDR_NDA_UP, {nib[1], 4'hF});
			wr(ADDR_NDA_LO, {4'hF, nib[0]});
			wr(ADDR_NDB_UP, {nib[3], 4'hF});
			wr(ADDR_NDB_LO, {4'hF, nib[2]});
			for (int c = 0; c < NUM_GRP; c++) begin
				for (int g = 0; g < NUM_GRP; g++)
					if (2'(g + k) == 2'(c)) expPins[4*g+:4] = nib[g];
				pulse(4'(1 << c));
			end
		end
		$display("test transfer done");
	endtask
	task automatic tMask();
		wr(ADDR_TRIG_SEL, RST_TRIG_SEL);
		wr(ADDR_EN_LO, 8'h3C);
		wr(ADDR_EN_HI, 8'hC3);
		wr(ADDR_NDA_UP, 8'hFF);
		wr(ADDR_NDB_UP, 8'hFF);
		wr(ADDR_LATCH_A, 8'h00);
		wr(ADDR_LATCH_B, 8'h00);
		expPins &= 16'hC33C;
		rd(ADDR_LATCH_A, expPins[7:0]);
		rd(ADDR_LATCH_B, expPins[15:8]);
		expPins |= 16'hC33C;
		pulse(4'h8);
		#1 chk("pinsLow", expPins[7:0], pinSeen[7:0]);
		chk("pinsHigh", expPins[15:8], pinSeen[15:8]);
		@(posedge ref_clk);
		$display("test mask done");
	endtask
	task automatic tStandby();
		wr(ADDR_NDA_UP, 8'h77);
		wr(ADDR_TRIG_SEL, 8'h1B);
		hwStandby_n <= 1'h0;
		repeat (6) @(posedge ref_clk);
		hwStandby_n <= 1'h1;
		repeat (6) @(posedge ref_clk);
		chkCleared();
		$display("test standby done");
	endtask
	task automatic tFreeze();
		wr(ADDR_EN_LO, 8'hFF);
		wr(ADDR_NDA_UP, 8'h5A);
		expPins = '0;
		clkEn <= 1'h0;
		pulse(4'h8);
		wr(ADDR_EN_LO, 8'h00);
		clkEn <= 1'h1;
		rd(ADDR_EN_LO, 8'hFF);
		expPins[7:0] = 8'h5A;
		pulse(4'h8);
		$display("test freeze done");
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'h1;
		@(posedge ref_clk);
		chkCleared();
		rd(16'hFFA8, RD_UNMAPPED);
		$display("test reset done");
		tLayout();
		tXfer();
		tMask();
		tStandby();
		tFreeze();
		finishTest();
	end
endmodule // pond_top_tb
